// *** include/panel_cfg_map.svh ***
/*
  Command opcodes, field positions and reset values for the panel
  configuration and timing command decoder. Assumes nothing beyond a
  single inclusion per compilation unit, which the guard provides.
*/
`ifndef PANEL_CFG_MAP_SVH
`define PANEL_CFG_MAP_SVH

`define OP_START_LINE_MASK 8'hC0
`define OP_START_LINE_BASE 8'h40
`define OP_SEG_REMAP_MASK 8'hFE
`define OP_SEG_REMAP_BASE 8'hA0
`define OP_COM_SCAN_MASK 8'hF7
`define OP_COM_SCAN_BASE 8'hC0
`define OP_MUX_RATIO 8'hA8
`define OP_DISP_OFFSET 8'hD3
`define OP_COM_PINS 8'hDA
`define OP_CLK_DIV 8'hD5
`define OP_PRECHARGE 8'hD9
`define OP_DESELECT 8'hDB
`define OP_NOP 8'hE3

`define COM_PINS_BIT 4
`define COM_SCAN_BIT 3

`define RST_START_LINE 6'h00
`define RST_SEG_REMAP 1'h0
`define RST_MUX_FIELD 6'h3F
`define RST_COM_REVERSE 1'h0
`define RST_DISP_OFFSET 6'h00
`define RST_COM_ALT 1'h1
`define RST_DIV_FIELD 4'h0
`define RST_OSC_CODE 4'h8
`define RST_PHASE1 4'h2
`define RST_PHASE2 4'h2
`define RST_DESELECT 3'h2

`endif

// *** include/panel_cfg_pkg.sv ***
/*
  Types for the panel configuration and timing command decoder.
  Assumes the constants header supplies all numeric values.
*/
package panel_cfg_pkg;

  typedef struct packed {
    logic [5:0] start_line;
    logic seg_remap;
    logic [5:0] mux_field;
    logic com_reverse;
    logic [5:0] disp_offset;
    logic com_alt;
    logic [3:0] div_field;
    logic [3:0] oscillator_frequency_code;
    logic [3:0] phase1;
    logic [3:0] phase2;
    logic [2:0] common_deselect_level;
  } panel_cfg_t;

  typedef enum logic [2:0] {
    PEND_MUX,
    PEND_OFFSET,
    PEND_PINS,
    PEND_CLK,
    PEND_PRE,
    PEND_DESEL
  } pend_op_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cmd_byte_t;

endpackage

// *** hdl/cmd_byte_sync.sv ***
/*
  Two-stage synchroniser for the incoming command byte strobe, with the
  byte and data/command level captured beside it.
  Assumes the host holds byte and level steady while its strobe toggles.
*/
`timescale 1ns/10ps
module cmd_byte_sync (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Asynchronous host side
  input wire logic strobe_toggle_in,
  input wire logic [7:0] byte_in,
  input wire logic dc_in,
  // Synchronous side
  output panel_cfg_pkg::cmd_byte_t cmd_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic [7:0] b1_ff;
  logic [7:0] b2_ff;
  logic d1_ff;
  logic d2_ff;
  panel_cfg_pkg::cmd_byte_t cmd_ff;
  wire edge_seen = s2_ff ^ s3_ff;

  // Data settles long before the strobe edge, so a two-flop byte path suffices
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_ff <= 1'h0;
      s2_ff <= 1'h0;
      s3_ff <= 1'h0;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      d1_ff <= 1'h1;
      d2_ff <= 1'h1;
      cmd_ff <= '0;
    end else begin
      s1_ff <= strobe_toggle_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      b1_ff <= byte_in;
      b2_ff <= b1_ff;
      d1_ff <= dc_in;
      d2_ff <= d1_ff;
      cmd_ff.valid <= edge_seen & ~d2_ff;
      cmd_ff.data <= b2_ff;
    end
  end

  assign cmd_out = cmd_ff;
endmodule

// *** hdl/panel_config_timing_cmd_decoder.sv ***
/*
  Decoder for the hardware-configuration and timing command bytes of a
  dot-matrix panel controller; holds the resulting settings.
  Assumes the host delivers command bytes by toggling a strobe, holding
  byte and data/command level steady around each toggle.
*/
// Notes on behaviour
// (R1) A byte 0x40..0x7F loads its low six bits as the display start line.
// (R2) 0xA0 maps column 0 to the first segment (reset); 0xA1 maps column 127 there.
// (R3) 0xA8 plus a parameter sets the multiplex field to its low six bits, reset 63.
// (R4) The host never sends a multiplex parameter of 0 to 14.
// (R5) 0xC0 scans commons upward (reset); 0xC8 scans them in reverse.
// (R6) 0xD3 plus a parameter sets the vertical offset to its low six bits, reset 0.
// (R7) 0xDA plus a parameter picks the pin layout from bit 4, alternative at reset.
// (R8) 0xD5 low nibble sets the divider field, ratio field plus one, reset 0.
// (R9) 0xD5 high nibble sets the oscillator frequency code, reset 8.
// (R10) 0xD9 low nibble sets pre-charge phase one, reset 2.
// (R11) 0xD9 high nibble sets phase two, reset 2; the host never sends zero.
// (R12) 0xDB stores parameter bits 6..4 as the deselect level code, reset 2.
// (R13) 0xE3 does nothing when no parameter is due; after a two-byte opcode it is taken as the parameter.
// (R14) The host sends all these bytes in command mode.
// (R15) After a two-byte opcode the next command byte is its parameter.
`timescale 1ns/10ps
`include "panel_cfg_map.svh"
module panel_config_timing_cmd_decoder (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Host byte path
  input wire logic strobe_toggle_in,
  input wire logic [7:0] byte_in,
  input wire logic dc_in,
  // Settings
  output logic [5:0] start_line_out,
  output logic seg_remap_out,
  output logic [6:0] row_multiplex_ratio_out,
  output logic com_reverse_out,
  output logic [5:0] disp_offset_out,
  output logic com_alt_out,
  output logic [4:0] divide_ratio_out,
  output logic [3:0] oscillator_frequency_code_out,
  output logic [3:0] phase1_out,
  output logic [3:0] phase2_out,
  output logic [2:0] common_deselect_level_out,
  // Status
  output logic param_pending_out,
  output logic divided_display_clock_out
);
  panel_cfg_pkg::cmd_byte_t cmd;
  panel_cfg_pkg::panel_cfg_t cfg_ff;
  panel_cfg_pkg::panel_cfg_t nxt_cfg;
  panel_cfg_pkg::pend_op_t pend_ff;
  panel_cfg_pkg::pend_op_t nxt_pend;
  logic pending_ff;
  logic nxt_pending;
  logic [6:0] mux_ff;
  logic [4:0] ratio_ff;
  logic [3:0] div_cnt_ff;
  logic divided_display_clock_ff;
  logic [4:0] gap_ff;

  cmd_byte_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .strobe_toggle_in(strobe_toggle_in),
    .byte_in(byte_in),
    .dc_in(dc_in),
    .cmd_out(cmd)
  );

  // Opcode decode, used for both first byte and match tests
  function automatic logic is_op(input logic [7:0] b, input logic [7:0] mask,
                                 input logic [7:0] base);
    is_op = (b & mask) == base;
  endfunction

  wire [7:0] b = cmd.data;
  wire take_param = cmd.valid & pending_ff; // R15
  wire take_op = cmd.valid & ~pending_ff;
  wire op_start = take_op & is_op(b, `OP_START_LINE_MASK, `OP_START_LINE_BASE);
  wire op_seg = take_op & is_op(b, `OP_SEG_REMAP_MASK, `OP_SEG_REMAP_BASE);
  wire op_scan = take_op & is_op(b, `OP_COM_SCAN_MASK, `OP_COM_SCAN_BASE);
  wire op_mux = take_op & (b == `OP_MUX_RATIO);
  wire op_off = take_op & (b == `OP_DISP_OFFSET);
  wire op_pins = take_op & (b == `OP_COM_PINS);
  wire op_clk = take_op & (b == `OP_CLK_DIV);
  wire op_pre = take_op & (b == `OP_PRECHARGE);
  wire op_des = take_op & (b == `OP_DESELECT);
  wire two_byte = op_mux | op_off | op_pins | op_clk | op_pre | op_des;
  // A NOP sent where a parameter is due is still a parameter, per byte order
  wire op_nop = take_op & (b == `OP_NOP);
  wire op_known = op_start | op_seg | op_scan | two_byte;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_pending = pending_ff;
    nxt_pend = pend_ff;
    if (op_start) begin
      nxt_cfg.start_line = b[5:0]; // R1
    end
    if (op_seg) begin
      nxt_cfg.seg_remap = b[0]; // R2
    end
    if (op_scan) begin
      nxt_cfg.com_reverse = b[`COM_SCAN_BIT]; // R5
    end
    if (two_byte) begin
      nxt_pending = 1'h1; // R15
      case (1'b1)
        op_mux: nxt_pend = panel_cfg_pkg::PEND_MUX;
        op_off: nxt_pend = panel_cfg_pkg::PEND_OFFSET;
        op_pins: nxt_pend = panel_cfg_pkg::PEND_PINS;
        op_clk: nxt_pend = panel_cfg_pkg::PEND_CLK;
        op_pre: nxt_pend = panel_cfg_pkg::PEND_PRE;
        default: nxt_pend = panel_cfg_pkg::PEND_DESEL;
      endcase
    end
    if (take_param) begin
      nxt_pending = 1'h0;
      case (pend_ff)
        panel_cfg_pkg::PEND_MUX: nxt_cfg.mux_field = b[5:0]; // R3 R4
        panel_cfg_pkg::PEND_OFFSET: nxt_cfg.disp_offset = b[5:0]; // R6
        panel_cfg_pkg::PEND_PINS: nxt_cfg.com_alt = b[`COM_PINS_BIT]; // R7
        panel_cfg_pkg::PEND_CLK: begin
          nxt_cfg.div_field = b[3:0]; // R8
          nxt_cfg.oscillator_frequency_code = b[7:4]; // R9
        end
        panel_cfg_pkg::PEND_PRE: begin
          nxt_cfg.phase1 = b[3:0]; // R10
          nxt_cfg.phase2 = b[7:4]; // R11
        end
        panel_cfg_pkg::PEND_DESEL: nxt_cfg.common_deselect_level = b[6:4]; // R12
        default: nxt_pending = 1'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_ff.start_line <= `RST_START_LINE;
      cfg_ff.seg_remap <= `RST_SEG_REMAP;
      cfg_ff.mux_field <= `RST_MUX_FIELD;
      cfg_ff.com_reverse <= `RST_COM_REVERSE;
      cfg_ff.disp_offset <= `RST_DISP_OFFSET;
      cfg_ff.com_alt <= `RST_COM_ALT;
      cfg_ff.div_field <= `RST_DIV_FIELD;
      cfg_ff.oscillator_frequency_code <= `RST_OSC_CODE;
      cfg_ff.phase1 <= `RST_PHASE1;
      cfg_ff.phase2 <= `RST_PHASE2;
      cfg_ff.common_deselect_level <= `RST_DESELECT;
      pending_ff <= 1'h0;
      pend_ff <= panel_cfg_pkg::PEND_MUX;
    end else begin
      cfg_ff <= nxt_cfg;
      pending_ff <= nxt_pending;
      pend_ff <= nxt_pend;
    end
  end

  // Derived values registered so every output is a flop
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mux_ff <= 7'h40;
      ratio_ff <= 5'h01;
    end else begin
      mux_ff <= {1'b0, cfg_ff.mux_field} + 7'h01; // R3
      ratio_ff <= {1'b0, cfg_ff.div_field} + 5'h01; // R8
    end
  end

  // Divided display clock as an enable pulse, one per ratio cycles
  wire div_wrap = div_cnt_ff >= cfg_ff.div_field;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt_ff <= 4'h0;
      divided_display_clock_ff <= 1'h0;
    end else begin
      div_cnt_ff <= div_wrap ? 4'h0 : div_cnt_ff + 4'h1; // R8
      divided_display_clock_ff <= div_wrap;
    end
  end

  // Checker helper: cycles since the last divided clock pulse
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_ff <= 5'h00;
    end else begin
      gap_ff <= divided_display_clock_ff ? 5'h00 : gap_ff + 5'h01;
    end
  end

  assign start_line_out = cfg_ff.start_line;
  assign seg_remap_out = cfg_ff.seg_remap;
  assign row_multiplex_ratio_out = mux_ff;
  assign com_reverse_out = cfg_ff.com_reverse;
  assign disp_offset_out = cfg_ff.disp_offset;
  assign com_alt_out = cfg_ff.com_alt;
  assign divide_ratio_out = ratio_ff;
  assign oscillator_frequency_code_out = cfg_ff.oscillator_frequency_code;
  assign phase1_out = cfg_ff.phase1;
  assign phase2_out = cfg_ff.phase2;
  assign common_deselect_level_out = cfg_ff.common_deselect_level;
  assign param_pending_out = pending_ff;
  assign divided_display_clock_out = divided_display_clock_ff;

  AST_START_LINE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_start |=> start_line_out == $past(b[5:0])) else $error("start line not loaded"); // R1
  AST_SEG: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_seg |=> seg_remap_out == $past(b[0])) else $error("segment remap wrong"); // R2
  AST_MUX: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_param && pend_ff == panel_cfg_pkg::PEND_MUX) |=> ##1
    row_multiplex_ratio_out == {1'b0, $past(b[5:0], 2)} + 7'h01) else $error("mux ratio wrong"); // R3
  AST_SCAN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_scan |=> com_reverse_out == $past(b[3])) else $error("scan direction wrong"); // R5
  AST_OFFSET: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_param && pend_ff == panel_cfg_pkg::PEND_OFFSET) |=>
    disp_offset_out == $past(b[5:0])) else $error("offset wrong"); // R6
  AST_PINS: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_param && pend_ff == panel_cfg_pkg::PEND_PINS) |=>
    com_alt_out == $past(b[4])) else $error("pin layout wrong"); // R7
  AST_CLK: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_param && pend_ff == panel_cfg_pkg::PEND_CLK) |=>
    oscillator_frequency_code_out == $past(b[7:4]) ##1
    divide_ratio_out == {1'b0, $past(b[3:0], 2)} + 5'h01) else $error("clock setting wrong"); // R8 R9
  AST_PRE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_param && pend_ff == panel_cfg_pkg::PEND_PRE) |=>
    {phase2_out, phase1_out} == $past(b)) else $error("precharge wrong"); // R10 R11
  AST_DESEL: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_param && pend_ff == panel_cfg_pkg::PEND_DESEL) |=>
    common_deselect_level_out == $past(b[6:4])) else $error("deselect wrong"); // R12
  AST_NOP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_nop |=> $stable(cfg_ff) && $stable(pending_ff)) else $error("nop changed state"); // R13
  AST_PARAM: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    two_byte |=> param_pending_out)
    else $error("parameter not awaited"); // R15
  AST_PARAM_DONE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    take_param |=> !param_pending_out) else $error("parameter wait not ended"); // R15
  AST_PARAM_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (pending_ff && !cmd.valid) |=> param_pending_out && $stable(pend_ff))
    else $error("parameter wait lost"); // R15
  AST_UNKNOWN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (take_op && !op_known) |=> $stable(cfg_ff) && !param_pending_out)
    else $error("unknown opcode acted on"); // R15
  AST_START_HOLD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !op_start |=> $stable(start_line_out)) else $error("start line moved"); // R1
  AST_MUX_OUT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    row_multiplex_ratio_out == {1'b0, $past(cfg_ff.mux_field)} + 7'h01)
    else $error("mux ratio not field plus one"); // R3
  AST_DIV_OUT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    divide_ratio_out == {1'b0, $past(cfg_ff.div_field)} + 5'h01)
    else $error("divide ratio not field plus one"); // R8
  // A ratio of one must give a pulse on every cycle
  AST_DIVIDED_DISPLAY_CLOCK_EVERY: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (cfg_ff.div_field == 4'h0) |=> divided_display_clock_ff) else $error("divided clock missing"); // R8
  // Even the largest ratio of sixteen leaves at most fifteen idle cycles
  AST_DIVIDED_DISPLAY_CLOCK_GAP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    gap_ff < 5'h10) else $error("divided clock gap too long"); // R8

  COV_MUX: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_mux ##[1:40] take_param);
  COV_CLK: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_clk ##[1:40] take_param);
  COV_NOP: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) op_nop);
  COV_START: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) op_start);
  COV_PRE: cover property (@(posedge clk_sys_in) disable iff (!nrst_in)
    op_pre ##[1:40] take_param);
endmodule

// *** verif/host_cmd_model.sv ***
/*
  Host model that delivers command bytes by toggling a strobe.
  Assumes the caller spaces calls; each call ends settled past the answer.
*/
`timescale 1ns/10ps
module host_cmd_model (
  // Clock
  input wire logic clk_sys_in,
  // Byte path towards the decoder
  output logic strobe_toggle_out,
  output logic [7:0] byte_out,
  output logic dc_out
);
  initial begin
    strobe_toggle_out = 1'b0;
    byte_out = 8'h00;
    dc_out = 1'b1;
  end

  // Lines past their hold time show the inverse, so a late sample never matches by luck
  task automatic send(input logic [7:0] value, input logic is_data);
    @(posedge clk_sys_in);
    #1;
    byte_out = value;
    dc_out = is_data;
    repeat (3) @(posedge clk_sys_in);
    #1;
    strobe_toggle_out = ~strobe_toggle_out;
    repeat (4) @(posedge clk_sys_in);
    #1;
    byte_out = ~value;
    dc_out = ~is_data;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
endmodule

// *** verif/tb_panel_config_timing_cmd_decoder.sv ***
/*
  Self-checking bench for the panel configuration and timing command decoder.
  Assumes the host model paces every byte well apart from the next.
*/
`timescale 1ns/10ps
module tb_panel_config_timing_cmd_decoder;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic strobe_toggle;
  logic [7:0] host_byte;
  logic host_dc;
  logic [5:0] start_line;
  logic seg_remap;
  logic [6:0] mux_ratio;
  logic com_reverse;
  logic [5:0] disp_offset;
  logic com_alt;
  logic [4:0] div_ratio;
  logic [3:0] osc_code;
  logic [3:0] phase1;
  logic [3:0] phase2;
  logic [2:0] deselect;
  logic pending;
  logic divided_display_clock;
  int err_total = 0;
  int compares = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  host_cmd_model i_host_cmd_model (
    .clk_sys_in(clk_sys_in),
    .strobe_toggle_out(strobe_toggle),
    .byte_out(host_byte),
    .dc_out(host_dc)
  );

  panel_config_timing_cmd_decoder i_panel_config_timing_cmd_decoder (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .strobe_toggle_in(strobe_toggle),
    .byte_in(host_byte),
    .dc_in(host_dc),
    .start_line_out(start_line),
    .seg_remap_out(seg_remap),
    .row_multiplex_ratio_out(mux_ratio),
    .com_reverse_out(com_reverse),
    .disp_offset_out(disp_offset),
    .com_alt_out(com_alt),
    .divide_ratio_out(div_ratio),
    .oscillator_frequency_code_out(osc_code),
    .phase1_out(phase1),
    .phase2_out(phase2),
    .common_deselect_level_out(deselect),
    .param_pending_out(pending),
    .divided_display_clock_out(divided_display_clock)
  );

  task automatic complete_run();
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic op(input logic [7:0] b);
    i_host_cmd_model.send(b, 1'b0);
  endtask

  task automatic op2(input logic [7:0] opc, input logic [7:0] prm);
    op(opc);
    op(prm);
  endtask

  // Counts divided clock pulses over a fixed window of 40 cycles
  task automatic chk_divided_display_clock(input logic [7:0] exp);
    logic [7:0] cnt;
    cnt = 8'h00;
    repeat (40) begin
      @(posedge clk_sys_in);
      #1;
      if (divided_display_clock === 1'b1) cnt++;
    end
    chk(cnt, exp);
  endtask

  task automatic check_reset();
    chk(8'(start_line), 8'h00);
    chk(8'(seg_remap), 8'h00);
    chk(8'(mux_ratio), 8'h40);
    chk(8'(com_reverse), 8'h00);
    chk(8'(disp_offset), 8'h00);
    chk(8'(com_alt), 8'h01);
    chk(8'(div_ratio), 8'h01);
    chk(8'(osc_code), 8'h08);
    chk(8'(phase1), 8'h02);
    chk(8'(phase2), 8'h02);
    chk(8'(deselect), 8'h02);
    chk(8'(pending), 8'h00);
    chk_divided_display_clock(8'h28);
  endtask

  task automatic t_start_line();
    op(8'h40);
    chk(8'(start_line), 8'h00);
    op(8'h7F);
    chk(8'(start_line), 8'h3F);
    i_host_cmd_model.send(8'h55, 1'b1);
    chk(8'(start_line), 8'h3F);
    op(8'h55);
    chk(8'(start_line), 8'h15);
  endtask

  task automatic t_remap_scan();
    op(8'hA1);
    chk(8'(seg_remap), 8'h01);
    op(8'hA0);
    chk(8'(seg_remap), 8'h00);
    op(8'hC8);
    chk(8'(com_reverse), 8'h01);
    op(8'hC0);
    chk(8'(com_reverse), 8'h00);
  endtask

  task automatic t_mux();
    op(8'hA8);
    chk(8'(pending), 8'h01);
    op(8'h0F);
    chk(8'(pending), 8'h00);
    chk(8'(mux_ratio), 8'h10);
    op2(8'hA8, 8'hFF);
    chk(8'(mux_ratio), 8'h40);
  endtask

  task automatic t_offset_pins();
    op2(8'hD3, 8'hE3);
    chk(8'(disp_offset), 8'h23);
    op2(8'hD3, 8'hC5);
    chk(8'(disp_offset), 8'h05);
    op2(8'hDA, 8'hA1);
    chk(8'(com_alt), 8'h00);
    chk(8'(seg_remap), 8'h00);
    op2(8'hDA, 8'h10);
    chk(8'(com_alt), 8'h01);
  endtask

  task automatic t_clk_pre();
    op2(8'hD5, 8'hF3);
    chk(8'(div_ratio), 8'h04);
    chk(8'(osc_code), 8'h0F);
    chk_divided_display_clock(8'h0A);
    op2(8'hD9, 8'hF1);
    chk(8'(phase1), 8'h01);
    chk(8'(phase2), 8'h0F);
    op2(8'hDB, 8'h30);
    chk(8'(deselect), 8'h03);
    op2(8'hDB, 8'h8F);
    chk(8'(deselect), 8'h00);
  endtask

  task automatic t_nop();
    op(8'hA1);
    op(8'hE3);
    chk(8'(seg_remap), 8'h01);
    chk(8'(start_line), 8'h15);
    chk(8'(osc_code), 8'h0F);
    chk(8'(pending), 8'h00);
  endtask

  // Sized well above the roughly 470 cycles the sequence needs
  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    check_reset();
    t_start_line();
    t_remap_scan();
    t_mux();
    t_offset_pins();
    t_clk_pre();
    t_nop();
    nrst_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    check_reset();
    complete_run();
  end
endmodule
